/* logic/qdcs_top.sv */
// quad divider configuration select: set storage, i2c target, selection, modulator, output drive
// Operation
// - four divider sets; freq_select picks the set, freq_select_1 is upper bit
// - output_enable low floats both clock outputs, high drives them
// - output_enable reaches the drivers without any clock
// - reset loads factory presets into all four sets
// - host reads any set back over i2c
// - host writes divider fields of any set after reset
// - registers are volatile; every reset restores the presets
// - a freq_select change switches the synthesizer after the input synchroniser and the output register
// - set fields are 2-bit pre, 7-bit int, 18-bit frac, 7-bit post
// - fout is fref/(pre*post) times int plus (frac+0.5)/2^18
// - reference is 114.285 MHz or 100 MHz by variant
// - fractional feedback comes from a delta-sigma modulator
// - 6-bit control voltage gain field steers the pull path
`timescale 1ns/1ps
module qdcs_top
    import qdcs_pkg::*;
#(
    parameter logic [6:0] I2C_ADDR     = QDCS_I2C_ADDR_DFLT,
    parameter logic       XTAL_VARIANT = 1'b0
)
(
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    input  wire logic        freq_select_0_in,
    input  wire logic        freq_select_1_in,
    input  wire logic        output_enable_in,
    input  wire logic        synth_clk_in,
    output logic             clock_true_out,
    output logic             clock_out_comp_out,
    output logic             clock_oe_out,
    output logic      [1:0]  pre_divider_out,
    output logic      [6:0]  feedback_int_out,
    output logic      [17:0] feedback_frac_out,
    output logic      [6:0]  post_divider_out,
    output logic      [7:0]  feedback_ratio_out,
    output logic      [5:0]  control_voltage_gain_out,
    output logic      [16:0] xtal_khz_out
);
    logic [3:0]  sync_q;
    logic        scl;
    logic        sda;
    logic        scl_d;
    logic        sda_d;
    logic [1:0]  sel;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;

    logic [1:0]  cfg_p    [0:3];
    logic [6:0]  cfg_feedback_int [0:3];
    logic [17:0] cfg_frac [0:3];
    logic [6:0]  cfg_n    [0:3];
    logic [5:0]  gain;

    qdcs_state_e state;
    logic [7:0]  shift;
    logic [3:0]  bitcnt;
    logic [7:0]  ptr;
    logic        rw;
    logic        sda_drive;
    logic [7:0]  tx_byte;
    logic [7:0]  rd_byte;
    logic        wr_commit;

    logic [18:0] dsm_acc;
    logic [19:0] dsm_sum;
    logic        after_rst;

    qdcs_sync u_sync
    (
        .clk_in   (ref_clk_in),
        .reset_in (reset_in),
        .async_in ({freq_select_1_in, freq_select_0_in, sda_in, scl_in}),
        .sync_out (sync_q)
    );

    assign scl = sync_q[0];
    assign sda = sync_q[1];
    assign sel = sync_q[3:2];

    // output drivers: combinational so the enable needs no clock edge
    assign clock_true_out     = synth_clk_in;
    assign clock_out_comp_out = ~synth_clk_in;
    assign clock_oe_out       = output_enable_in;

    // open drain: drive low only while enabled
    assign sda_out    = 1'b0;
    assign sda_oe_out = sda_drive;

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    assign scl_rise  = scl & ~scl_d;
    assign scl_fall  = ~scl & scl_d;
    assign start_det = scl & scl_d & sda_d & ~sda;
    assign stop_det  = scl & scl_d & ~sda_d & sda;
    assign wr_commit = (state == QDCS_ST_WDATA) && scl_fall && (bitcnt == QDCS_BITS);

    // read mux; unmapped bytes and unused bits read zero
    always_comb
    begin
        rd_byte = 8'h00;
        if (ptr == QDCS_OFS_GAIN)
            rd_byte = {2'h0, gain};
        else if (qdcs_is_cfg(ptr))
        begin
            case (ptr[2:0])
                QDCS_FLD_P:        rd_byte = {6'h00, cfg_p[ptr[4:3]]};
                QDCS_FLD_FEEDBACK_INT:     rd_byte = {1'b0, cfg_feedback_int[ptr[4:3]]};
                QDCS_FLD_FRAC_HI:  rd_byte = {6'h00, cfg_frac[ptr[4:3]][17:16]};
                QDCS_FLD_FRAC_MID: rd_byte = cfg_frac[ptr[4:3]][15:8];
                QDCS_FLD_FRAC_LO:  rd_byte = cfg_frac[ptr[4:3]][7:0];
                QDCS_FLD_N:        rd_byte = {1'b0, cfg_n[ptr[4:3]]};
                default:           rd_byte = 8'h00;
            endcase
        end
    end

    // i2c target; start and stop win over any bit in progress
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state     <= QDCS_ST_IDLE;
            shift     <= 8'h00;
            bitcnt    <= 4'h0;
            ptr       <= 8'h00;
            rw        <= 1'b0;
            sda_drive <= 1'b0;
            tx_byte   <= 8'h00;
        end
        else if (start_det)
        begin
            state     <= QDCS_ST_ADDR;
            bitcnt    <= 4'h0;
            sda_drive <= 1'b0;
        end
        else if (stop_det)
        begin
            state     <= QDCS_ST_IDLE;
            sda_drive <= 1'b0;
        end
        else
        begin
            case (state)
                QDCS_ST_ADDR, QDCS_ST_REG, QDCS_ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift  <= {shift[6:0], sda};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    else if (scl_fall && bitcnt == QDCS_BITS)
                    begin
                        bitcnt <= 4'h0;
                        if (state == QDCS_ST_ADDR)
                        begin
                            if (shift[7:1] == I2C_ADDR)
                            begin
                                sda_drive <= 1'b1;
                                rw        <= shift[0];
                                state     <= QDCS_ST_ACK_ADDR;
                            end
                            else
                                state <= QDCS_ST_IDLE;
                        end
                        else if (state == QDCS_ST_REG)
                        begin
                            ptr       <= shift;
                            sda_drive <= 1'b1;
                            state     <= QDCS_ST_ACK_REG;
                        end
                        else
                        begin
                            ptr       <= ptr + 8'h01;
                            sda_drive <= 1'b1;
                            state     <= QDCS_ST_ACK_W;
                        end
                    end
                end
                QDCS_ST_ACK_ADDR, QDCS_ST_ACK_REG, QDCS_ST_ACK_W, QDCS_ST_RNEXT:
                begin
                    if (scl_fall)
                    begin
                        if ((state == QDCS_ST_ACK_ADDR && rw) || state == QDCS_ST_RNEXT)
                        begin
                            tx_byte   <= {rd_byte[6:0], 1'b0};
                            sda_drive <= ~rd_byte[7];
                            bitcnt    <= 4'h1;
                            state     <= QDCS_ST_RDATA;
                        end
                        else
                        begin
                            sda_drive <= 1'b0;
                            state     <= (state == QDCS_ST_ACK_ADDR) ? QDCS_ST_REG : QDCS_ST_WDATA;
                        end
                    end
                end
                QDCS_ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bitcnt == QDCS_BITS)
                        begin
                            sda_drive <= 1'b0;
                            ptr       <= ptr + 8'h01;
                            state     <= QDCS_ST_RACK;
                        end
                        else
                        begin
                            sda_drive <= ~tx_byte[7];
                            tx_byte   <= {tx_byte[6:0], 1'b0};
                            bitcnt    <= bitcnt + 4'h1;
                        end
                    end
                end
                QDCS_ST_RACK:
                begin
                    // host nack ends the read; wait for stop or start
                    if (scl_rise)
                        state <= sda ? QDCS_ST_IDLE : QDCS_ST_RNEXT;
                end
                QDCS_ST_IDLE:
                    state <= QDCS_ST_IDLE;
                default:
                    state <= QDCS_ST_IDLE;
            endcase
        end
    end

    // configuration storage; each byte commits on its own, so a frac update is briefly mixed
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            for (int i = 0; i < QDCS_SETS; i++)
            begin
                cfg_p[i]    <= QDCS_RST_P[i];
                cfg_feedback_int[i] <= QDCS_RST_FEEDBACK_INT[i];
                cfg_frac[i] <= QDCS_RST_FRAC[i];
                cfg_n[i]    <= QDCS_RST_N[i];
            end
            gain <= QDCS_RST_GAIN;
        end
        else if (wr_commit)
        begin
            if (ptr == QDCS_OFS_GAIN)
                gain <= shift[5:0];
            else if (qdcs_is_cfg(ptr))
            begin
                case (ptr[2:0])
                    QDCS_FLD_P:        cfg_p[ptr[4:3]]           <= shift[1:0];
                    QDCS_FLD_FEEDBACK_INT:     cfg_feedback_int[ptr[4:3]]        <= shift[6:0];
                    QDCS_FLD_FRAC_HI:  cfg_frac[ptr[4:3]][17:16] <= shift[1:0];
                    QDCS_FLD_FRAC_MID: cfg_frac[ptr[4:3]][15:8]  <= shift;
                    QDCS_FLD_FRAC_LO:  cfg_frac[ptr[4:3]][7:0]   <= shift;
                    QDCS_FLD_N:        cfg_n[ptr[4:3]]           <= shift[6:0];
                    default:           gain                      <= gain;
                endcase
            end
        end
    end

    // divider outputs track the selected set every cycle, so writes show two cycles after the commit
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pre_divider_out          <= QDCS_RST_P[0];
            feedback_int_out         <= QDCS_RST_FEEDBACK_INT[0];
            feedback_frac_out        <= QDCS_RST_FRAC[0];
            post_divider_out         <= QDCS_RST_N[0];
            control_voltage_gain_out <= QDCS_RST_GAIN;
            xtal_khz_out             <= QDCS_XTAL_KHZ_A;
        end
        else
        begin
            pre_divider_out          <= cfg_p[sel];
            feedback_int_out         <= cfg_feedback_int[sel];
            feedback_frac_out        <= cfg_frac[sel];
            post_divider_out         <= cfg_n[sel];
            control_voltage_gain_out <= gain;
            xtal_khz_out             <= XTAL_VARIANT ? QDCS_XTAL_KHZ_B : QDCS_XTAL_KHZ_A;
        end
    end

    // first-order modulator; the forced lsb adds the half step of the fraction
    assign dsm_sum = {1'b0, dsm_acc} + {1'b0, cfg_frac[sel], 1'b1};

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            dsm_acc            <= 19'h00000;
            feedback_ratio_out <= {1'b0, QDCS_RST_FEEDBACK_INT[0]};
        end
        else
        begin
            dsm_acc            <= dsm_sum[18:0];
            feedback_ratio_out <= {1'b0, cfg_feedback_int[sel]} + {7'h00, dsm_sum[19]};
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            after_rst <= 1'b1;
        else
            after_rst <= 1'b0;
    end

    default clocking qdcs_cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    a_oe_float: assert property (!output_enable_in |-> !clock_oe_out)
        else $error("clock driver enabled while output enable low");
    a_comp_inverse: assert property (clock_out_comp_out == !clock_true_out && clock_oe_out == output_enable_in)
        else $error("complement output or async enable wrong");
    a_preset_load: assert property (after_rst |-> cfg_p[0] == QDCS_RST_P[0] && cfg_feedback_int[1] == QDCS_RST_FEEDBACK_INT[1]
                                    && cfg_frac[2] == QDCS_RST_FRAC[2] && cfg_n[3] == QDCS_RST_N[3])
        else $error("presets not loaded after reset");
    a_sel_route: assert property ((sel == 2'h2) |=> feedback_frac_out == $past(cfg_frac[2]))
        else $error("selected set not routed");
    a_sel_switch: assert property ($changed(sel) && sel == 2'h3 |=> post_divider_out == $past(cfg_n[3]))
        else $error("select change not applied at once");
    a_write_commit: assert property ((wr_commit && ptr == 8'h15) |=> cfg_n[2] == $past(shift[6:0]))
        else $error("write not committed to set");
    a_live_follow: assert property ((wr_commit && ptr == 8'h11 && sel == 2'h2) ##1 (sel == 2'h2)
                                    |=> feedback_int_out == $past(shift[6:0], 2))
        else $error("selected set write not followed");
    a_gain_write: assert property ((wr_commit && ptr == QDCS_OFS_GAIN)
                                   |=> ##1 control_voltage_gain_out == $past(shift[5:0], 2))
        else $error("gain field not applied");
    a_ratio_range: assert property ((feedback_ratio_out - {1'b0, feedback_int_out}) <= 8'h01)
        else $error("modulated ratio outside int and int plus one");
    a_addr_nack: assert property ((state == QDCS_ST_ADDR && scl_fall && !start_det && !stop_det
                                   && bitcnt == QDCS_BITS && shift[7:1] != I2C_ADDR)
                                  |=> !sda_drive && state == QDCS_ST_IDLE)
        else $error("foreign address acknowledged");
endmodule : qdcs_top

/* logic/qdcs_pkg.sv */
// shared constants, state codes and decode helpers of the quad divider configuration select block
package qdcs_pkg;

    // number of configuration sets and i2c byte length
    localparam int          QDCS_SETS          = 4;
    localparam logic [3:0]  QDCS_BITS          = 4'h8;

    // default target address, plain value
    localparam logic [6:0]  QDCS_I2C_ADDR_DFLT = 7'h6e;

    // byte map: set n occupies 8'h08*n .. 8'h08*n+5, gain sits above the sets
    localparam logic [7:0]  QDCS_OFS_GAIN      = 8'h20;
    localparam logic [2:0]  QDCS_FLD_P         = 3'h0;
    localparam logic [2:0]  QDCS_FLD_FEEDBACK_INT      = 3'h1;
    localparam logic [2:0]  QDCS_FLD_FRAC_HI   = 3'h2;
    localparam logic [2:0]  QDCS_FLD_FRAC_MID  = 3'h3;
    localparam logic [2:0]  QDCS_FLD_FRAC_LO   = 3'h4;
    localparam logic [2:0]  QDCS_FLD_N         = 3'h5;

    // factory presets loaded at every reset
    localparam logic [1:0]  QDCS_RST_P    [0:3] = '{2'h1, 2'h1, 2'h1, 2'h1};
    localparam logic [6:0]  QDCS_RST_FEEDBACK_INT [0:3] = '{7'h19, 7'h18, 7'h1a, 7'h1b};
    localparam logic [17:0] QDCS_RST_FRAC [0:3] = '{18'h00000, 18'h10000, 18'h20000, 18'h08000};
    localparam logic [6:0]  QDCS_RST_N    [0:3] = '{7'h04, 7'h04, 7'h08, 7'h08};
    localparam logic [5:0]  QDCS_RST_GAIN       = 6'h01;

    // synchroniser idle levels, order {freq_select_1, freq_select_0, sda, scl}
    localparam logic [3:0]  QDCS_SYNC_RST      = 4'h3;

    // reference variants in kHz
    localparam logic [16:0] QDCS_XTAL_KHZ_A    = 17'h1be6d;
    localparam logic [16:0] QDCS_XTAL_KHZ_B    = 17'h186a0;

    typedef enum logic [9:0] {
        QDCS_ST_IDLE     = 10'h001,
        QDCS_ST_ADDR     = 10'h002,
        QDCS_ST_ACK_ADDR = 10'h004,
        QDCS_ST_REG      = 10'h008,
        QDCS_ST_ACK_REG  = 10'h010,
        QDCS_ST_WDATA    = 10'h020,
        QDCS_ST_ACK_W    = 10'h040,
        QDCS_ST_RDATA    = 10'h080,
        QDCS_ST_RACK     = 10'h100,
        QDCS_ST_RNEXT    = 10'h200
    } qdcs_state_e;

    // true when the byte pointer lands on a divider field
    function automatic logic qdcs_is_cfg(input logic [7:0] ptr);
        qdcs_is_cfg = (ptr < QDCS_OFS_GAIN) && (ptr[2:0] <= QDCS_FLD_N);
    endfunction : qdcs_is_cfg

endpackage : qdcs_pkg

/* logic/qdcs_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module qdcs_sync
    import qdcs_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic [3:0] async_in,
    output logic      [3:0] sync_out
);
    logic [3:0] stage1;
    logic [3:0] stage2;
    logic [3:0] stage3;

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            stage1 <= QDCS_SYNC_RST;
            stage2 <= QDCS_SYNC_RST;
            stage3 <= QDCS_SYNC_RST;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a bit moves only once the last two stages agree
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            sync_out <= QDCS_SYNC_RST;
        else
            sync_out <= (stage2 & stage3) | (sync_out & (stage2 ^ stage3));
    end
endmodule : qdcs_sync

/* testbench/qdcs_host_model.sv */
// i2c host model that drives the configuration port of the block
`timescale 1ns/1ps
module qdcs_host_model
#(
    parameter int Q_CYC = 6,
    parameter int H_CYC = 10
)
(
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // both lines high at time zero: scl driven high by the host, sda released so the pull-up holds it high
    initial
    begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : wait_cyc

    // also a repeated start when entered with the clock low
    task automatic i2c_start();
        sda_low_out = 1'b0;
        wait_cyc(Q_CYC);
        scl_out = 1'b1;
        wait_cyc(H_CYC);
        sda_low_out = 1'b1;
        wait_cyc(H_CYC);
        scl_out = 1'b0;
        wait_cyc(Q_CYC);
    endtask : i2c_start

    task automatic i2c_stop();
        sda_low_out = 1'b1;
        wait_cyc(Q_CYC);
        scl_out = 1'b1;
        wait_cyc(H_CYC);
        sda_low_out = 1'b0;
        wait_cyc(H_CYC);
    endtask : i2c_stop

    // data changes only while the clock is low, msb first
    task automatic i2c_tx(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_low_out = ~b[i];
            wait_cyc(Q_CYC);
            scl_out = 1'b1;
            wait_cyc(H_CYC);
            scl_out = 1'b0;
            wait_cyc(Q_CYC);
        end
        sda_low_out = 1'b0;
        wait_cyc(Q_CYC);
        scl_out = 1'b1;
        wait_cyc(H_CYC / 2);
        ack = ~sda_in;
        wait_cyc(H_CYC / 2);
        scl_out = 1'b0;
        wait_cyc(Q_CYC);
    endtask : i2c_tx

    // ack bit waits past the synchroniser lag so it never looks like a start or stop
    task automatic i2c_rx(input logic nack, output logic [7:0] b);
        sda_low_out = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            wait_cyc(Q_CYC);
            scl_out = 1'b1;
            wait_cyc(H_CYC / 2);
            b = {b[6:0], sda_in};
            wait_cyc(H_CYC / 2);
            scl_out = 1'b0;
        end
        wait_cyc(Q_CYC);
        sda_low_out = ~nack;
        wait_cyc(Q_CYC);
        scl_out = 1'b1;
        wait_cyc(H_CYC);
        scl_out = 1'b0;
        wait_cyc(Q_CYC);
    endtask : i2c_rx
endmodule : qdcs_host_model

/* testbench/testbench.sv */
// self-checking bench of the quad divider configuration select block
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("ERROR %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module testbench
    import qdcs_pkg::*;
;
    logic        clk, rst, scl, sda_low, sda_wire, freq_select_0, freq_select_1, oe, synth;
    logic        sda_oe, sda_dout, clk_true, clk_comp, clk_oe, ack;
    logic [1:0]  pre;
    logic [6:0]  feedback_int, post;
    logic [17:0] frac;
    logic [7:0]  ratio;
    logic [5:0]  gain;
    logic [16:0] xtal;
    logic [7:0]  wbuf [0:7];
    logic [7:0]  rbuf [0:7];
    int          num_errors = 0;
    int          compares = 0;

    // open-drain wire with pull-up; the device puts its data value on it while enabled
    assign sda_wire = (sda_low || (sda_oe && !sda_dout)) ? 1'b0 : 1'b1;
    initial
    begin
        clk   = 1'b0;
        synth = 1'b0;
    end
    always #50 clk = ~clk;
    always #13 synth = ~synth;

    qdcs_top qdcs_top_i (.ref_clk_in(clk), .reset_in(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_dout),
        .sda_oe_out(sda_oe), .freq_select_0_in(freq_select_0), .freq_select_1_in(freq_select_1), .output_enable_in(oe),
        .synth_clk_in(synth), .clock_true_out(clk_true), .clock_out_comp_out(clk_comp), .clock_oe_out(clk_oe),
        .pre_divider_out(pre), .feedback_int_out(feedback_int), .feedback_frac_out(frac), .post_divider_out(post),
        .feedback_ratio_out(ratio), .control_voltage_gain_out(gain), .xtal_khz_out(xtal));
    qdcs_host_model qdcs_host_model_i (.clk_in(clk), .sda_in(sda_wire), .scl_out(scl), .sda_low_out(sda_low));

    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if ((num_errors == 0) && (compares > 0))
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // fixed settle span: three-stage sync plus the output register
    task automatic set_sel(input logic [1:0] s);
        @(negedge clk);
        freq_select_1 = s[1];
        freq_select_0 = s[0];
        repeat (6) @(negedge clk);
    endtask : set_sel

    task automatic chk_vals(input logic [1:0] p, input logic [6:0] i, input logic [17:0] f, input logic [6:0] n);
        `CHK(pre, p)
        `CHK(feedback_int, i)
        `CHK(frac, f)
        `CHK(post, n)
    endtask : chk_vals

    task automatic chk_set(input int n);
        chk_vals(QDCS_RST_P[n], QDCS_RST_FEEDBACK_INT[n], QDCS_RST_FRAC[n], QDCS_RST_N[n]);
    endtask : chk_set

    task automatic i2c_addr(input logic rd);
        qdcs_host_model_i.i2c_start();
        qdcs_host_model_i.i2c_tx({QDCS_I2C_ADDR_DFLT, rd}, ack);
        `CHK(ack, 1'b1)
    endtask : i2c_addr

    task automatic i2c_wr(input logic [7:0] ptr, input int n);
        i2c_addr(1'b0);
        qdcs_host_model_i.i2c_tx(ptr, ack);
        `CHK(ack, 1'b1)
        for (int k = 0; k < n; k++)
        begin
            qdcs_host_model_i.i2c_tx(wbuf[k], ack);
            `CHK(ack, 1'b1)
        end
        qdcs_host_model_i.i2c_stop();
    endtask : i2c_wr

    task automatic i2c_rd(input logic [7:0] ptr, input int n);
        i2c_addr(1'b0);
        qdcs_host_model_i.i2c_tx(ptr, ack);
        `CHK(ack, 1'b1)
        i2c_addr(1'b1);
        for (int k = 0; k < n; k++)
            qdcs_host_model_i.i2c_rx(k == n - 1, rbuf[k]);
        qdcs_host_model_i.i2c_stop();
    endtask : i2c_rd

    task automatic t_presets();
        for (int s = 0; s < QDCS_SETS; s++)
        begin
            set_sel(s[1:0]);
            chk_set(s);
        end
        `CHK(xtal, QDCS_XTAL_KHZ_A)
        `CHK(gain, QDCS_RST_GAIN)
    endtask : t_presets

    // enable checked well before the next rising edge, so no clock can be involved
    task automatic t_clock_out();
        for (int k = 0; k < 4; k++)
        begin
            @(negedge clk);
            oe = k[0];
            #1;
            `CHK(clk_oe, oe)
            `CHK(clk_true, synth)
            `CHK(clk_comp, ~synth)
        end
        oe = 1'b1;
    endtask : t_clock_out

    // host keeps to an unselected set and a frequency inside the legal band
    task automatic t_write_other();
        set_sel(2'h0);
        wbuf = '{8'h02, 8'h30, 8'h01, 8'h23, 8'h45, 8'h06, 8'h00, 8'h00};
        i2c_wr(8'h10, 6);
        chk_set(0);
        set_sel(2'h2);
        chk_vals(2'h2, 7'h30, 18'h12345, 7'h06);
        i2c_rd(8'h10, 8);
        for (int k = 0; k < 8; k++)
            `CHK(rbuf[k], wbuf[k])
    endtask : t_write_other

    task automatic t_write_selected();
        wbuf[0] = 8'h31;
        i2c_wr(8'h11, 1);
        `CHK(feedback_int, 7'h31)
        wbuf[0] = 8'h2a;
        i2c_wr(QDCS_OFS_GAIN, 1);
        `CHK(gain, 6'h2a)
    endtask : t_write_selected

    task automatic t_bad_addr();
        qdcs_host_model_i.i2c_start();
        qdcs_host_model_i.i2c_tx(8'ha0, ack);
        `CHK(ack, 1'b0)
        qdcs_host_model_i.i2c_stop();
    endtask : t_bad_addr

    task automatic t_power_cycle();
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        `CHK(sda_oe, 1'b0)
        `CHK(feedback_int, QDCS_RST_FEEDBACK_INT[0])
        rst = 1'b0;
        repeat (6) @(negedge clk);
        chk_set(2);
        `CHK(gain, QDCS_RST_GAIN)
    endtask : t_power_cycle

    // carry count of the accumulator over a window, one count of slack for its start value
    task automatic t_modulator();
        int      cnt;
        int      bad;
        longint  expc;
        cnt  = 0;
        bad  = 0;
        expc = (longint'(1024) * (2 * longint'(QDCS_RST_FRAC[2]) + 1)) >> 19;
        repeat (1024)
        begin
            @(negedge clk);
            if (ratio === ({1'b0, feedback_int} + 8'h01))
                cnt++;
            else if (ratio !== {1'b0, feedback_int})
                bad++;
        end
        `CHK(bad, 0)
        `CHK((cnt >= expc - 1) && (cnt <= expc + 1), 1'b1)
    endtask : t_modulator

    initial
    begin
        #3_000_000;
        num_errors++;
        give_verdict();
    end

    initial
    begin
        rst   = 1'b1;
        freq_select_0 = 1'b0;
        freq_select_1 = 1'b0;
        oe    = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        t_presets();
        t_clock_out();
        t_write_other();
        t_write_selected();
        t_bad_addr();
        t_power_cycle();
        t_modulator();
        give_verdict();
    end
endmodule : testbench
